// file: verilog/sram_fifo_map.vh
`ifndef SRAM_FIFO_MAP_VH
`define SRAM_FIFO_MAP_VH

// storage and organisation
`define MEM_BITS 4608
`define MEM_WORDS 128
`define MEM_WORD_BITS 36
`define MEM_ADDR_BITS 7

// width codes for either port: 0=36 1=18 2=9 3=4 4=2 5=1
`define WIDTH_36 3'h0
`define WIDTH_18 3'h1
`define WIDTH_9 3'h2
`define WIDTH_4 3'h3
`define WIDTH_2 3'h4
`define WIDTH_1 3'h5

// bit address width for 4608 bits
`define BIT_ADDR_BITS 13
`define COUNT_BITS 14

// register offsets (word addresses)
`define REG_CONTROL 4'h0
`define REG_NEAR_EMPTY_LVL 4'h1
`define REG_NEAR_FULL_LVL 4'h2
`define REG_STATUS 4'h3
`define REG_EVENTS 4'h4
`define REG_MASK 4'h5
`define REG_LEVEL 4'h6

// control field positions
`define CTL_FIFO_MODE 0
`define CTL_WR_WIDTH_LO 1
`define CTL_RD_WIDTH_LO 4
`define CTL_DEPTH_LO 8
`define CTL_RESET_VAL 32'h0000_0001
`define NEAR_EMPTY_RESET 14'h0000
`define NEAR_FULL_RESET 14'h1200

// status and event bit positions
`define ST_EMPTY 0
`define ST_FULL 1
`define ST_NEAR_EMPTY 2
`define ST_NEAR_FULL 3
`define EV_OVERFLOW 4
`define EV_UNDERFLOW 5
`define EV_BITS 6

`endif

// file: verilog/sram_array.v
`timescale 1ns/1ps
`default_nettype none
`include "sram_fifo_map.vh"

// ----------------------------------------
// row-addressed memory with per-bit lane write enables, 4608 bits
// ----------------------------------------
module sram_array #(
  parameter ROWS = `MEM_WORDS,
  parameter COLS = `MEM_WORD_BITS
) (
  // clock
  input wire clk,
  // write side, one word lane per bit
  input wire [COLS-1:0] wr_lane_en,
  input wire [`MEM_ADDR_BITS-1:0] wr_row,
  input wire [COLS-1:0] wr_data,
  // read side
  input wire [`MEM_ADDR_BITS-1:0] rd_row,
  output wire [COLS-1:0] rd_data
);
  // one single-bit array per lane, each with its own read register
  genvar b;
  generate
    for (b = 0; b < COLS; b = b + 1) begin : lane
      reg cells [0:ROWS-1];
      reg q;
      always @(posedge clk) begin
        if (wr_lane_en[b]) begin
          cells[wr_row] <= wr_data[b];
        end
        q <= cells[rd_row];
      end
      assign rd_data[b] = q;
    end
  endgenerate
endmodule
`default_nettype wire

// file: verilog/sram_fifo_block.v
// Design decisions made here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "sram_fifo_map.vh"

// Notes on behaviour
// - storage is 4608 bits for every port organisation.
// - organisations 128x36, 256x18, 512x9, 1152x4, 2304x2, 4608x1.
// - write and read ports have separate, independently chosen widths.
// - internal controller makes the block a synchronous fifo.
// - fifo width and depth are set by configuration.
// - empty, full, near-empty and near-full flags with set thresholds.
// - own counters form read and write pointers.
// - WR_EN and RD_EN pass synchronisers; flags derive from registered state only.
// - cascade ports share the full flag so that blocks chain wider.
module sram_fifo_block (
  // clock and reset
  input wire CLOCK,
  input wire SYS_RST,
  // avalon-mm slave
  input wire [3:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  output reg [31:0] AVS_READDATA,
  output reg AVS_WAITREQUEST,
  output reg IRQ,
  // write port
  input wire WR_EN,
  input wire [35:0] WR_DATA,
  input wire [`BIT_ADDR_BITS-1:0] WR_ADDR,
  // read port
  input wire RD_EN,
  input wire [`BIT_ADDR_BITS-1:0] RD_ADDR,
  output reg [35:0] RD_DATA,
  output reg RD_VALID,
  // flags
  output reg EMPTY,
  output reg FULL,
  output reg NEAR_EMPTY_FLAG,
  output reg NEAR_FULL_FLAG,
  // cascade
  input wire CASCADE_IN_FULL,
  output reg CASCADE_OUT_FULL
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [31:0] control;
  reg [`COUNT_BITS-1:0] near_empty_lvl;
  reg [`COUNT_BITS-1:0] near_full_lvl;
  reg [`EV_BITS-1:0] events;
  reg [`EV_BITS-1:0] mask;
  wire fifo_mode = control[`CTL_FIFO_MODE];
  wire [2:0] wr_code = control[`CTL_WR_WIDTH_LO+2:`CTL_WR_WIDTH_LO];
  wire [2:0] rd_code = control[`CTL_RD_WIDTH_LO+2:`CTL_RD_WIDTH_LO];
  wire [`COUNT_BITS-1:0] depth_bits = control[`CTL_DEPTH_LO+`COUNT_BITS-1:`CTL_DEPTH_LO];

  // ----------------------------------------
  // pin synchronisers, three stages
  // ----------------------------------------
  reg [2:0] wr_sync;
  reg [2:0] rd_sync;
  reg wr_level;
  reg rd_level;
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      wr_sync <= 3'h0;
      rd_sync <= 3'h0;
      wr_level <= 1'b0;
      rd_level <= 1'b0;
    end else begin
      wr_sync <= {wr_sync[1:0], WR_EN};
      rd_sync <= {rd_sync[1:0], RD_EN};
      if (wr_sync[1] == wr_sync[2]) begin
        wr_level <= wr_sync[2];
      end
      if (rd_sync[1] == rd_sync[2]) begin
        rd_level <= rd_sync[2];
      end
    end
  end
  reg wr_level_d;
  reg rd_level_d;
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      wr_level_d <= 1'b0;
      rd_level_d <= 1'b0;
    end else begin
      wr_level_d <= wr_level;
      rd_level_d <= rd_level;
    end
  end
  // one request per rising edge of the strobe
  wire wr_req = wr_level & ~wr_level_d;
  wire rd_req = rd_level & ~rd_level_d;

  // ----------------------------------------
  // width decode
  // ----------------------------------------
  function [5:0] width_of;
    input [2:0] code;
    begin
      case (code)
        `WIDTH_36: width_of = 6'd36;
        `WIDTH_18: width_of = 6'd18;
        `WIDTH_9: width_of = 6'd9;
        `WIDTH_4: width_of = 6'd4;
        `WIDTH_2: width_of = 6'd2;
        default: width_of = 6'd1;
      endcase
    end
  endfunction
  wire [5:0] wr_width = width_of(wr_code);
  wire [5:0] rd_width = width_of(rd_code);

  // ----------------------------------------
  // array geometry
  // ----------------------------------------
  localparam [`COUNT_BITS-1:0] CAP_MAX = `MEM_BITS;
  localparam [`COUNT_BITS-1:0] ROW_BITS = `MEM_WORD_BITS;
  // fifo depth in bits, clamped to the array
  wire [`COUNT_BITS-1:0] cap_bits =
    (depth_bits == {`COUNT_BITS{1'b0}} || depth_bits > CAP_MAX) ?
    CAP_MAX : depth_bits;

  // ----------------------------------------
  // pointers and level, counted in bits
  // ----------------------------------------
  reg [`COUNT_BITS-1:0] wr_ptr;
  reg [`COUNT_BITS-1:0] rd_ptr;
  reg [`COUNT_BITS-1:0] level;
  wire [`COUNT_BITS-1:0] wr_w = {{(`COUNT_BITS-6){1'b0}}, wr_width};
  wire [`COUNT_BITS-1:0] rd_w = {{(`COUNT_BITS-6){1'b0}}, rd_width};
  wire room = (level + wr_w <= cap_bits) & ~CASCADE_IN_FULL;
  wire have = (level >= rd_w);
  wire do_wr = wr_req & (~fifo_mode | room);
  wire do_rd = rd_req & (~fifo_mode | have);

  function [`COUNT_BITS-1:0] wrap;
    input [`COUNT_BITS-1:0] p;
    input [`COUNT_BITS-1:0] step;
    input [`COUNT_BITS-1:0] cap;
    reg [`COUNT_BITS-1:0] s;
    begin
      s = p + step;
      wrap = (s >= cap) ? s - cap : s;
    end
  endfunction

  wire [`COUNT_BITS-1:0] wr_base = fifo_mode ? wr_ptr : {1'b0, WR_ADDR};
  wire [`COUNT_BITS-1:0] rd_base = fifo_mode ? rd_ptr : {1'b0, RD_ADDR};

  always @(posedge CLOCK) begin
    if (SYS_RST || !fifo_mode) begin
      wr_ptr <= {`COUNT_BITS{1'b0}};
      rd_ptr <= {`COUNT_BITS{1'b0}};
      level <= {`COUNT_BITS{1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= wrap(wr_ptr, wr_w, cap_bits);
      end
      if (do_rd) begin
        rd_ptr <= wrap(rd_ptr, rd_w, cap_bits);
      end
      case ({do_wr, do_rd})
        2'b10: level <= level + wr_w;
        2'b01: level <= level - rd_w;
        2'b11: level <= level + wr_w - rd_w;
        default: level <= level;
      endcase
    end
  end

  // ----------------------------------------
  // memory: bit address split to row and lane
  // ----------------------------------------
  reg [35:0] wr_lane_en;
  reg [35:0] wr_bits;
  reg [`MEM_ADDR_BITS-1:0] wr_row;
  wire [`COUNT_BITS-1:0] wr_bit0 = wr_base - (wr_base % wr_w);
  wire [`COUNT_BITS-1:0] rd_bit0 = rd_base - (rd_base % rd_w);
  // lane and row of the first bit of each word
  wire [`COUNT_BITS-1:0] wr_col_full = wr_bit0 % ROW_BITS;
  wire [`COUNT_BITS-1:0] rd_col_full = rd_bit0 % ROW_BITS;
  wire [`COUNT_BITS-1:0] wr_row_full = wr_bit0 / ROW_BITS;
  wire [`COUNT_BITS-1:0] rd_row_full = rd_bit0 / ROW_BITS;
  wire [5:0] wr_col = wr_col_full[5:0];
  wire [5:0] rd_col = rd_col_full[5:0];
  wire [`MEM_ADDR_BITS-1:0] rd_row = rd_row_full[`MEM_ADDR_BITS-1:0];
  integer i;
  always @* begin
    wr_lane_en = 36'h0;
    wr_bits = 36'h0;
    wr_row = wr_row_full[`MEM_ADDR_BITS-1:0];
    for (i = 0; i < 36; i = i + 1) begin
      if (do_wr && i >= wr_col && i < wr_col + wr_width) begin
        wr_lane_en[i] = 1'b1;
        wr_bits[i] = WR_DATA[i - wr_col];
      end
    end
  end
  wire [35:0] row_out;
  sram_array u_array (
    .clk(CLOCK),
    .wr_lane_en(wr_lane_en),
    .wr_row(wr_row),
    .wr_data(wr_bits),
    .rd_row(rd_row),
    .rd_data(row_out)
  );
  reg rd_pend;
  reg [5:0] rd_col_q;
  reg [5:0] rd_width_q;
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      rd_pend <= 1'b0;
      rd_col_q <= 6'h0;
      rd_width_q <= 6'h0;
    end else begin
      rd_pend <= do_rd;
      rd_col_q <= rd_col;
      rd_width_q <= rd_width;
    end
  end
  wire [35:0] shifted = row_out >> rd_col_q;
  wire [35:0] width_mask = ~(36'hf_ffff_ffff << rd_width_q);
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      RD_DATA <= 36'h0;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= rd_pend;
      if (rd_pend) begin
        RD_DATA <= shifted & width_mask;
      end
    end
  end

  // ----------------------------------------
  // flags
  // ----------------------------------------
  wire f_empty = fifo_mode & (level < rd_w);
  wire f_full = fifo_mode & (level + wr_w > cap_bits);
  wire f_near_e = fifo_mode & (level <= near_empty_lvl);
  wire f_near_f = fifo_mode & (level >= near_full_lvl);
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      EMPTY <= 1'b1;
      FULL <= 1'b0;
      NEAR_EMPTY_FLAG <= 1'b1;
      NEAR_FULL_FLAG <= 1'b0;
      CASCADE_OUT_FULL <= 1'b0;
    end else begin
      EMPTY <= f_empty;
      FULL <= f_full;
      NEAR_EMPTY_FLAG <= f_near_e;
      NEAR_FULL_FLAG <= f_near_f;
      CASCADE_OUT_FULL <= f_full;
    end
  end

  // ----------------------------------------
  // event capture
  // ----------------------------------------
  wire [`EV_BITS-1:0] ev_now = {rd_req & ~do_rd, wr_req & ~do_wr,
    f_near_f, f_near_e, f_full, f_empty};
  // cleared on the edge that captures the read data, so nothing is lost
  wire ev_read = AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == `REG_EVENTS;
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      events <= {`EV_BITS{1'b0}};
    end else if (ev_read) begin
      // set wins over the clearing read
      events <= ev_now;
    end else begin
      events <= events | ev_now;
    end
  end

  // ----------------------------------------
  // avalon slave, one wait cycle
  // ----------------------------------------
  reg [31:0] next_readdata;
  always @* begin
    case (AVS_ADDRESS)
      `REG_CONTROL: next_readdata = control;
      `REG_NEAR_EMPTY_LVL: next_readdata = {18'h0, near_empty_lvl};
      `REG_NEAR_FULL_LVL: next_readdata = {18'h0, near_full_lvl};
      `REG_STATUS: next_readdata = {28'h0, f_near_f, f_near_e, f_full, f_empty};
      `REG_EVENTS: next_readdata = {26'h0, events};
      `REG_MASK: next_readdata = {26'h0, mask};
      `REG_LEVEL: next_readdata = {18'h0, level};
      default: next_readdata = 32'h0;
    endcase
  end
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0;
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(events & mask);
      if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) begin
        AVS_WAITREQUEST <= 1'b0;
        if (AVS_READ) begin
          AVS_READDATA <= next_readdata;
        end
      end else begin
        AVS_WAITREQUEST <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // register writes, on the edge after the answering edge, while waitrequest is low
  // ----------------------------------------
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      control <= `CTL_RESET_VAL;
      near_empty_lvl <= `NEAR_EMPTY_RESET;
      near_full_lvl <= `NEAR_FULL_RESET;
      mask <= {`EV_BITS{1'b0}};
    end else if (AVS_WRITE && !AVS_WAITREQUEST) begin
      case (AVS_ADDRESS)
        `REG_CONTROL: control <= AVS_WRITEDATA;
        `REG_NEAR_EMPTY_LVL: near_empty_lvl <= AVS_WRITEDATA[13:0];
        `REG_NEAR_FULL_LVL: near_full_lvl <= AVS_WRITEDATA[13:0];
        `REG_MASK: mask <= AVS_WRITEDATA[5:0];
        default: control <= control;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: dv/fifo_checks_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// flag and bus checks
// ----------------------------------------
module fifo_checks (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // bus
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  input wire logic IRQ,
  // ports and flags
  input wire logic WR_EN,
  input wire logic RD_VALID,
  input wire logic EMPTY,
  input wire logic FULL,
  input wire logic NEAR_EMPTY_FLAG,
  input wire logic CASCADE_OUT_FULL
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);
  AST_RESET_STATE: assert property (disable iff (1'b0)
    SYS_RST |=> EMPTY && !FULL && !IRQ && AVS_WAITREQUEST) else $error("bad reset state");
  AST_FLAG_EXCL: assert property (!(FULL && EMPTY)) else $error("full and empty");
  AST_NEAR_EMPTY: assert property (EMPTY |-> NEAR_EMPTY_FLAG) else $error("near empty low");
  AST_CHAIN_OUT: assert property (CASCADE_OUT_FULL == FULL) else $error("chain full");
  AST_WAIT_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("wait");
  AST_ANSWER: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=>
    !AVS_WAITREQUEST) else $error("no answer");
  AST_VALID_PULSE: assert property (RD_VALID |=> !RD_VALID) else $error("valid long");
  AST_NO_READ_EMPTY: assert property (RD_VALID |-> !$past(EMPTY)) else $error("read empty");
  AST_FULL_BY_WRITE: assert property ($rose(FULL) |-> $past(WR_EN, 3)) else $error("full");
  cover property (FULL);
  cover property (RD_VALID);
  cover property (IRQ);
endmodule
bind sram_fifo_block fifo_checks i_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .IRQ(IRQ), .WR_EN(WR_EN), .RD_VALID(RD_VALID), .EMPTY(EMPTY), .FULL(FULL),
  .NEAR_EMPTY_FLAG(NEAR_EMPTY_FLAG), .CASCADE_OUT_FULL(CASCADE_OUT_FULL));
`default_nettype wire

// file: dv/fabric_user.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// fabric logic on both fifo ports
// ----------------------------------------
module fabric_user (
  // clock
  input wire logic clk,
  // read return
  input wire logic rd_valid,
  input wire logic [35:0] rd_data,
  // requests
  output logic wr_en,
  output logic [35:0] wr_data,
  output logic rd_en,
  output logic chain_full
);
  initial begin
    wr_en = 1'b0;
    wr_data = 36'h0;
    rd_en = 1'b0;
    chain_full = 1'b0;
  end
  // level held long enough to pass the pin synchronisers
  task automatic push(input logic [35:0] d);
    @(posedge clk);
    wr_data <= d;
    wr_en <= 1'b1;
    repeat (6) @(posedge clk);
    wr_en <= 1'b0;
    wr_data <= ~d;
    repeat (6) @(posedge clk);
  endtask
  task automatic pop(output logic seen, output logic [35:0] got);
    seen = 1'b0;
    got = 36'h0;
    @(posedge clk);
    rd_en <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      if (i == 5) rd_en <= 1'b0;
      if (rd_valid === 1'b1) begin
        seen = 1'b1;
        got = rd_data;
      end
    end
  endtask
  task automatic chain(input logic b);
    @(posedge clk);
    chain_full <= b;
  endtask
endmodule
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// fifo block bench
// ----------------------------------------
module testbench;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [12:0] wr_addr = 13'h0;
  logic [12:0] rd_addr = 13'h0;
  wire [31:0] avs_readdata;
  wire [35:0] wr_data, rd_data;
  wire avs_waitrequest, irq, wr_en, rd_en, rd_valid, empty, full, near_empty, near_full;
  wire chain_in, chain_out;
  int err_total = 0;
  int check_count = 0;
  logic [31:0] rv;
  logic seen;
  logic [35:0] got;
  logic [35:0] v;
  always #25 clock = ~clock;
  sram_fifo_block i_dut (.CLOCK(clock), .SYS_RST(sys_rst), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .IRQ(irq),
    .WR_EN(wr_en), .WR_DATA(wr_data), .WR_ADDR(wr_addr), .RD_EN(rd_en),
    .RD_ADDR(rd_addr), .RD_DATA(rd_data), .RD_VALID(rd_valid), .EMPTY(empty),
    .FULL(full), .NEAR_EMPTY_FLAG(near_empty), .NEAR_FULL_FLAG(near_full),
    .CASCADE_IN_FULL(chain_in), .CASCADE_OUT_FULL(chain_out));
  fabric_user i_user (.clk(clock), .rd_valid(rd_valid), .rd_data(rd_data),
    .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .chain_full(chain_in));
  task automatic chk(input logic [35:0] s, input logic [35:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) err_total++;
  endtask
  task automatic t_reset;
    chk(empty, 1);
    chk(near_empty, 1);
    bus(0, 4'h0, 0, rv);
    chk(rv, 32'h1);
    bus(0, 4'h2, 0, rv);
    chk(rv, 32'd4608);
    bus(1, 4'hf, 32'hffff_ffff, rv);
    bus(0, 4'hf, 0, rv);
    chk(rv, 0);
  endtask
  // depth 36 bits, 9-bit words, thresholds 9 and 27
  task automatic t_flow;
    bus(1, 4'h0, 0, rv);
    bus(1, 4'h1, 32'd9, rv);
    bus(1, 4'h2, 32'd27, rv);
    bus(1, 4'h5, 32'h10, rv);
    bus(1, 4'h0, 32'h2425, rv);
    for (int i = 0; i < 4; i++) begin
      i_user.push(36'h1a0 + i);
      chk(empty, 0);
      chk(near_empty, 9 * (i + 1) <= 9);
      chk(near_full, 9 * (i + 1) >= 27);
      chk(full, i == 3);
      chk(chain_out, i == 3);
    end
    i_user.push(36'h0ff);
    bus(0, 4'h6, 0, rv);
    chk(rv, 32'd36);
    chk(irq, 1);
    bus(0, 4'h4, 0, rv);
    chk(rv[5:4], 2'b01);
    repeat (3) @(posedge clock);
    chk(irq, 0);
    for (int i = 0; i < 4; i++) begin
      i_user.pop(seen, got);
      chk({seen, got[8:0]}, {1'b1, 9'(9'h1a0 + i)});
      chk(empty, i == 3);
    end
    i_user.pop(seen, got);
    chk(seen, 0);
    chk(irq, 0);
    bus(0, 4'h4, 0, rv);
    chk(rv[5], 1);
  endtask
  // every organisation, same width both sides
  task automatic t_org;
    int wd [6] = '{36, 18, 9, 4, 2, 1};
    v = 36'h9_a5c3_6e1b;
    for (int c = 0; c < 6; c++) begin
      bus(1, 4'h0, 0, rv);
      bus(1, 4'h0, 32'h1 | (c << 1) | (c << 4), rv);
      i_user.push(v);
      i_user.pop(seen, got);
      chk(got & ((36'h1 << wd[c]) - 1), v & ((36'h1 << wd[c]) - 1));
    end
  endtask
  // written 18 wide, read 9 wide, low half first
  task automatic t_width;
    v = 36'h2b4c1;
    bus(1, 4'h0, 0, rv);
    bus(1, 4'h0, 32'h23, rv);
    i_user.push(v);
    bus(0, 4'h6, 0, rv);
    chk(rv, 32'd18);
    i_user.pop(seen, got);
    chk(got[8:0], v[8:0]);
    i_user.pop(seen, got);
    chk(got[8:0], v[17:9]);
  endtask
  task automatic t_chain;
    bus(1, 4'h0, 0, rv);
    bus(1, 4'h0, 32'h2425, rv);
    i_user.chain(1);
    i_user.push(36'h55);
    chk(empty, 1);
    i_user.chain(0);
    i_user.push(36'h55);
    chk(empty, 0);
  endtask
  // plain memory mode, 9-bit words at bit address 9
  task automatic t_ram;
    v = 36'h1c5;
    bus(1, 4'h0, 32'h24, rv);
    wr_addr <= 13'd9;
    rd_addr <= 13'd9;
    i_user.push(v);
    chk({empty, near_empty}, 2'b00);
    i_user.pop(seen, got);
    chk({seen, got[8:0]}, {1'b1, v[8:0]});
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset;
    t_flow;
    t_org;
    t_width;
    t_chain;
    t_ram;
    final_report;
  end
  initial begin
    #1000000;
    err_total++;
    final_report;
  end
endmodule
`default_nettype wire
